// file: logic/daa_regs_defs.svh
// Offsets, field positions, reset values and gain steps of the gain, chain,
// filter and calibration registers. Included by the register block.
`ifndef DAA_REGS_DEFS_SVH
`define DAA_REGS_DEFS_SVH

`define ADDR_GAIN_ID 8'h0D
`define ADDR_CHAIN 8'h0E
`define ADDR_FINE_GAIN 8'h0F
`define ADDR_FILTER 8'h10
`define ADDR_CAL 8'h11

`define RST_GAIN_ID 8'h00
`define RST_CHAIN 8'h02
`define RST_FINE_GAIN 8'h00
`define RST_FILTER 8'h08
`define RST_CAL 8'h00

`define BIT_INTL_FLAG 6
`define BIT_REV_HI 5
`define BIT_REV_LO 2
`define BIT_RX_COARSE 1
`define BIT_TX_COARSE 0

`define BIT_SLV_HI 7
`define BIT_SLV_LO 5
`define BIT_WSEL_HI 4
`define BIT_WSEL_LO 3
`define BIT_SPACING 2
`define BIT_RING_POL 1
`define BIT_CHAIN_EN 0

`define BIT_TX_MUTE 7
`define BIT_TX_ATT_HI 6
`define BIT_TX_ATT_LO 4
`define BIT_RX_MUTE 3
`define BIT_RX_GAIN_HI 2
`define BIT_RX_GAIN_LO 0

`define BIT_IIR_EN 4
`define FILTER_LOW_NIBBLE 4'h8

`define BIT_CAL_START 6
`define BIT_AUTO_CAL_OFF 5

`define WSEL_16 2'h0
`define WSEL_RSVD 2'h1
`define WSEL_15_ONE 2'h2
`define WSEL_15_ZERO 2'h3

`define SYNC_PERIOD_LONG 6'h20
`define SYNC_PERIOD_SHORT 6'h10

`define DB_COARSE_RX 5'h06
`define DB_COARSE_TX 5'h03
`define DB_STEP_MAX 5'h0C

`endif

// file: logic/daa_regs_pkg.sv
// Types shared by the gain, chain, filter and calibration register block.
// Carries no constants; those live in the defs header.
package daa_regs_pkg;

  typedef enum logic [1:0] {
    PIN_PLAIN = 2'b01,
    PIN_CHAIN = 2'b10
  } pin_mode_e;

  typedef struct packed {
    logic transmit_mute;
    logic receive_mute;
    logic [4:0] tx_atten_db;
    logic [4:0] rx_gain_db;
  } gain_out_s;

  typedef struct packed {
    logic [2:0] slave_count;
    logic rx_word_16;
    logic rx_lsb_forced;
    logic rx_lsb_value;
    logic sync_spacing_16;
  } chain_out_s;

endpackage

// file: logic/sync3.sv
// Three-stage synchroniser for inputs from outside the clk_sys domain.
// Output moves only once stages two and three agree.
`timescale 1ns/1ps
module sync3 #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] ff1;
  logic [W-1:0] ff2;
  logic [W-1:0] ff3;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ff1 <= '0;
      ff2 <= '0;
      ff3 <= '0;
    end else begin
      ff1 <= din;
      ff2 <= ff1;
      ff3 <= ff2;
    end
  end

  // Per-bit agreement keeps a half-settled bit from leaking out
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      dout <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (ff2[i] == ff3[i]) begin
          dout[i] <= ff3[i];
        end
      end
    end
  end
endmodule // sync3

// file: logic/daa_gain_chain_filter_cal_regs.sv
// Gain, daisy-chain, filter and calibration registers of the host-side chip.
// Assumes the serial-port logic decodes frames into reg_* strobes on clk_sys
// and supplies sclk_en, a one-cycle pulse per serial bit clock.
// Function
// - Bit 6 reads line-side international flag
// - Bits 5:2 read line-side revision
// - Coarse receive bit adds 6 dB
// - Coarse transmit bit adds 3 dB attenuation
// - Slave count field gives slaves directly
// - Word select picks 16 or 15-bit words
// - Spacing bit picks 32 or 16 clocks
// - Polarity bit sets ring output active level
// - Chain enable remaps both ring pins
// - Chain disabled ignores other chain bits
// - Bit 7 mutes transmit
// - Transmit attenuation 0 to 12 dB
// - Bit 3 mutes receive
// - Receive gain 0 to 12 dB
// - Filter bit selects recursive or FIR
// - Filter low nibble 8, top zero
// - Writing calibration bit starts calibration
// - Bit 5 disables auto calibration
`timescale 1ns/1ps
`include "daa_regs_defs.svh"
module daa_gain_chain_filter_cal_regs
  import daa_regs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic line_side_intl_flag,
  input wire logic [3:0] line_side_revision,
  input wire logic ring_detect_in,
  input wire logic sclk_en,
  input wire logic secondary_request_or_ring_out_in,
  output logic secondary_request_or_ring_out_out,
  output logic secondary_request_or_ring_out_oe_n,
  output logic ring_out_or_delayed_sync,
  output logic secondary_request,
  output logic frame_sync,
  output gain_out_s gain_out,
  output chain_out_s chain_out,
  output logic recursive_filter_enable,
  output logic manual_cal_start,
  output logic auto_cal_enable
);
  logic receive_gain;
  logic transmit_gain;
  logic [7:0] chain_control;
  logic [7:0] fine_gain_control;
  logic iir_bit;
  logic cal_start_bit;
  logic auto_cal_disable;
  logic intl_s;
  logic [3:0] rev_s;
  logic ring_s;
  logic sreq_s;
  logic [5:0] sync_cnt;
  logic delayed_sync;
  logic chain_en;
  pin_mode_e pin_mode;

  sync3 #(.W(7)) u_sync (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .din({line_side_intl_flag, line_side_revision, ring_detect_in,
          secondary_request_or_ring_out_in}),
    .dout({intl_s, rev_s, ring_s, sreq_s})
  );

  function automatic logic [4:0] step_db(input logic [2:0] code);
    logic [4:0] db;
    db = `DB_STEP_MAX;
    case (code[1:0])
      2'h0: db = 5'h00;
      2'h1: db = 5'h03;
      2'h2: db = 5'h06;
      2'h3: db = 5'h09;
      default: db = `DB_STEP_MAX;
    endcase
    if (code[2]) begin
      db = `DB_STEP_MAX;
    end
    return db;
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
    return a == target;
  endfunction

  // Register writes; reserved bits are never stored
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      receive_gain <= 1'(`RST_GAIN_ID >> `BIT_RX_COARSE);
      transmit_gain <= 1'(`RST_GAIN_ID >> `BIT_TX_COARSE);
    end else if (reg_wr && hit(reg_addr, `ADDR_GAIN_ID)) begin
      receive_gain <= reg_wdata[`BIT_RX_COARSE];
      transmit_gain <= reg_wdata[`BIT_TX_COARSE];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      chain_control <= `RST_CHAIN;
    end else if (reg_wr && hit(reg_addr, `ADDR_CHAIN)) begin
      chain_control <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      fine_gain_control <= `RST_FINE_GAIN;
    end else if (reg_wr && hit(reg_addr, `ADDR_FINE_GAIN)) begin
      fine_gain_control <= reg_wdata;
    end
  end

  // Fixed nibble and top bits are constants; only the enable is a flop
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      iir_bit <= 1'(`RST_FILTER >> `BIT_IIR_EN);
    end else if (reg_wr && hit(reg_addr, `ADDR_FILTER)) begin
      iir_bit <= reg_wdata[`BIT_IIR_EN];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cal_start_bit <= 1'b0;
      auto_cal_disable <= 1'b0;
    end else if (reg_wr && hit(reg_addr, `ADDR_CAL)) begin
      cal_start_bit <= reg_wdata[`BIT_CAL_START];
      auto_cal_disable <= reg_wdata[`BIT_AUTO_CAL_OFF];
    end
  end

  // Start pulse on every write of one, so a repeated write recalibrates
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      manual_cal_start <= 1'b0;
    end else begin
      manual_cal_start <= reg_wr && hit(reg_addr, `ADDR_CAL) &&
                          reg_wdata[`BIT_CAL_START];
    end
  end

  // Read port: one cycle of latency, unmapped addresses read zero
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      reg_rdata <= 8'h00;
      if (reg_rd) begin
        case (reg_addr)
          `ADDR_GAIN_ID: reg_rdata <= {1'b0, intl_s, rev_s, receive_gain,
                                       transmit_gain};
          `ADDR_CHAIN: reg_rdata <= chain_control;
          `ADDR_FINE_GAIN: reg_rdata <= fine_gain_control;
          `ADDR_FILTER: reg_rdata <= {3'h0, iir_bit, `FILTER_LOW_NIBBLE};
          `ADDR_CAL: reg_rdata <= {1'b0, cal_start_bit, auto_cal_disable,
                                   5'h00};
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      gain_out <= '0;
      recursive_filter_enable <= 1'b0;
      auto_cal_enable <= 1'b1;
    end else begin
      gain_out.transmit_mute <= fine_gain_control[`BIT_TX_MUTE];
      gain_out.receive_mute <= fine_gain_control[`BIT_RX_MUTE];
      // Coarse and fine add; software keeps one of them at zero
      gain_out.tx_atten_db <= step_db(fine_gain_control[`BIT_TX_ATT_HI:`BIT_TX_ATT_LO])
        + (transmit_gain ? `DB_COARSE_TX : 5'h00);
      gain_out.rx_gain_db <= step_db(fine_gain_control[`BIT_RX_GAIN_HI:`BIT_RX_GAIN_LO])
        + (receive_gain ? `DB_COARSE_RX : 5'h00);
      recursive_filter_enable <= iir_bit;
      auto_cal_enable <= !auto_cal_disable;
    end
  end

  assign chain_en = chain_control[`BIT_CHAIN_EN];
  assign pin_mode = chain_en ? PIN_CHAIN : PIN_PLAIN;

  // Effective chain settings; all defaults while chaining is off
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      chain_out <= '0;
      chain_out.rx_word_16 <= 1'b1;
    end else if (!chain_en) begin
      chain_out <= '0;
      chain_out.rx_word_16 <= 1'b1;
    end else begin
      chain_out.slave_count <= chain_control[`BIT_SLV_HI:`BIT_SLV_LO];
      // Reserved select code falls back to the full word
      case (chain_control[`BIT_WSEL_HI:`BIT_WSEL_LO])
        `WSEL_15_ONE: begin
          chain_out.rx_word_16 <= 1'b0;
          chain_out.rx_lsb_forced <= 1'b1;
          chain_out.rx_lsb_value <= 1'b1;
        end
        `WSEL_15_ZERO: begin
          chain_out.rx_word_16 <= 1'b0;
          chain_out.rx_lsb_forced <= 1'b1;
          chain_out.rx_lsb_value <= 1'b0;
        end
        default: begin
          chain_out.rx_word_16 <= 1'b1;
          chain_out.rx_lsb_forced <= 1'b0;
          chain_out.rx_lsb_value <= 1'b0;
        end
      endcase
      // Not forced when the slave count is nonzero; that stays with software
      chain_out.sync_spacing_16 <= chain_control[`BIT_SPACING];
    end
  end

  // Frame sync every 32 or 16 serial clocks, one serial clock wide
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      sync_cnt <= 6'h00;
      frame_sync <= 1'b0;
      delayed_sync <= 1'b0;
    end else if (sclk_en) begin
      delayed_sync <= frame_sync;
      if (sync_cnt >= (chain_out.sync_spacing_16 ? `SYNC_PERIOD_SHORT
                                                 : `SYNC_PERIOD_LONG) - 6'h01) begin
        sync_cnt <= 6'h00;
        frame_sync <= 1'b1;
      end else begin
        sync_cnt <= sync_cnt + 6'h01;
        frame_sync <= 1'b0;
      end
    end
  end

  // Pin remapping; ring_out_or_delayed_sync is active low outside chaining, shared pin released
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      secondary_request_or_ring_out_out <= 1'b1;
      secondary_request_or_ring_out_oe_n <= 1'b1;
      ring_out_or_delayed_sync <= 1'b1;
      secondary_request <= 1'b0;
    end else begin
      case (pin_mode)
        PIN_CHAIN: begin
          secondary_request_or_ring_out_oe_n <= 1'b0;
          secondary_request_or_ring_out_out <= chain_control[`BIT_RING_POL] ? ring_s
                                                                           : !ring_s;
          ring_out_or_delayed_sync <= delayed_sync;
          secondary_request <= 1'b0;
        end
        default: begin
          secondary_request_or_ring_out_oe_n <= 1'b1;
          secondary_request_or_ring_out_out <= 1'b1;
          ring_out_or_delayed_sync <= !ring_s;
          secondary_request <= sreq_s;
        end
      endcase
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence wr_fine_s(logic [7:0] d);
    reg_wr && reg_addr == `ADDR_FINE_GAIN && reg_wdata == d;
  endsequence

  intl_flag_read_a: assert property (reg_rd && reg_addr == `ADDR_GAIN_ID |=>
    reg_rvalid && reg_rdata[7:6] == {1'b0, $past(intl_s)})
    else $error("intl flag readback wrong");
  revision_read_a: assert property (reg_rd && reg_addr == `ADDR_GAIN_ID |=>
    reg_rdata[5:2] == $past(rev_s))
    else $error("revision readback wrong");
  coarse_rx_a: assert property (fine_gain_control[2:0] == 3'h0 && receive_gain
    ##1 fine_gain_control[2:0] == 3'h0 && receive_gain |-> gain_out.rx_gain_db == 5'h06)
    else $error("coarse receive gain not 6 dB");
  coarse_tx_a: assert property (fine_gain_control[6:4] == 3'h0 && transmit_gain
    ##1 fine_gain_control[6:4] == 3'h0 && transmit_gain |-> gain_out.tx_atten_db == 5'h03)
    else $error("coarse transmit attenuation not 3 dB");
  fine_gain_a: assert property (wr_fine_s(8'hC5) ##1 !reg_wr && !transmit_gain && !receive_gain
    |=> gain_out.transmit_mute && !gain_out.receive_mute && gain_out.tx_atten_db == 5'h0C
    && gain_out.rx_gain_db == 5'h0C)
    else $error("fine gain decode wrong");
  slave_count_a: assert property ($past(chain_en) |-> chain_out.slave_count ==
    $past(chain_control[7:5]))
    else $error("slave count not passed through");
  chain_off_a: assert property (!$past(chain_en) |-> chain_out.slave_count == 3'h0 &&
    chain_out.rx_word_16 && !chain_out.sync_spacing_16 && secondary_request_or_ring_out_oe_n)
    else $error("chain bits used while disabled");
  word_select_a: assert property ($past(chain_en) && $past(chain_control[4:3]) == 2'h3 |->
    !chain_out.rx_word_16 && chain_out.rx_lsb_forced && !chain_out.rx_lsb_value)
    else $error("word select decode wrong");
  sync_period_a: assert property (sclk_en && sync_cnt == 6'h0F && chain_out.sync_spacing_16
    |=> frame_sync)
    else $error("short frame sync period wrong");
  ring_pol_a: assert property ($past(chain_en) && !$past(chain_control[1]) |->
    secondary_request_or_ring_out_out == !$past(ring_s))
    else $error("ring output polarity wrong");
  chain_pins_a: assert property ($past(chain_en) |-> !secondary_request_or_ring_out_oe_n &&
    ring_out_or_delayed_sync == $past(delayed_sync))
    else $error("chain pin remap wrong");
  filter_read_a: assert property (reg_rd && reg_addr == `ADDR_FILTER |=>
    reg_rdata == {3'h0, $past(iir_bit), 4'h8})
    else $error("filter readback wrong");
  cal_pulse_a: assert property (reg_wr && reg_addr == `ADDR_CAL && reg_wdata[6] |=>
    manual_cal_start ##1 (manual_cal_start == $past(reg_wr && reg_addr == `ADDR_CAL &&
    reg_wdata[6])))
    else $error("calibration start pulse wrong");
  cal_read_a: assert property (reg_rd && reg_addr == `ADDR_CAL |=>
    reg_rdata[7] == 1'b0 && reg_rdata[4:0] == 5'h00)
    else $error("calibration reserved bits nonzero");
endmodule // daa_gain_chain_filter_cal_regs

// file: bench/dsp_model.sv
// Modem DSP model: issues register reads and writes on the strobe port.
// Assumes clk_sys from the bench; the bench calls wr and rd.
`timescale 1ns/1ps
module dsp_model (
  input wire logic clk_sys,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  logic timed_out;
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
    timed_out = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == 8'h10) v = {3'h0, d[4], 4'h8};
    if (a == 8'h0E && v[0] && v[7:5] != 3'h0) v[2] = 1'b1;
    if (a == 8'h11) v[7] = 1'b0;
    @(posedge clk_sys);
    #1;
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(posedge clk_sys);
    #1;
    reg_wr = 1'b0;
    // Released bus shows the inverse, never a stale copy
    reg_addr = ~a;
    reg_wdata = ~v;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    d = 8'hXX;
    @(posedge clk_sys);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk_sys);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    for (n = 0; n < 4 && reg_rvalid !== 1'b1; n++) begin
      @(posedge clk_sys);
      #1;
    end
    if (reg_rvalid === 1'b1) d = reg_rdata;
    else timed_out = 1'b1;
  endtask
endmodule // dsp_model

// file: bench/test_daa_gain_chain_filter_cal_regs.sv
// Self-checking bench for the gain, chain, filter and calibration registers.
// Assumes dsp_model drives the strobe port; pin level resolved here.
`timescale 1ns/1ps
module test_daa_gain_chain_filter_cal_regs
  import daa_regs_pkg::*;
;
  logic clk_sys, resetn, reg_wr, reg_rd, reg_rvalid, intl, ring, req_drv, sclk_en;
  logic pin_out, pin_oe_n, pin_wire, ring_sync_out, sec_req, frame_sync, filt;
  logic cal_start, auto_cal, fs_prev;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [3:0] rev;
  gain_out_s gain_out;
  chain_out_s chain_out;
  int n_errors = 0;
  int check_count = 0;
  int sclk_cnt = 0;
  int fs_per = 0;
  integer seed = 32'h5233;

  // Released pin floats back to the requester's level
  assign pin_wire = pin_oe_n ? req_drv : pin_out;

  dsp_model dsp (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  daa_gain_chain_filter_cal_regs DUT (.clk_sys(clk_sys), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .line_side_intl_flag(intl),
    .line_side_revision(rev), .ring_detect_in(ring), .sclk_en(sclk_en),
    .secondary_request_or_ring_out_in(pin_wire),
    .secondary_request_or_ring_out_out(pin_out),
    .secondary_request_or_ring_out_oe_n(pin_oe_n),
    .ring_out_or_delayed_sync(ring_sync_out), .secondary_request(sec_req),
    .frame_sync(frame_sync), .gain_out(gain_out), .chain_out(chain_out),
    .recursive_filter_enable(filt), .manual_cal_start(cal_start), .auto_cal_enable(auto_cal));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) sclk_en <= #1 ~sclk_en;

  // Serial clocks between frame sync rises; sclk_en alternates so counts are exact
  always @(posedge clk_sys) begin
    fs_prev <= frame_sync;
    if (frame_sync === 1'b1 && fs_prev === 1'b0) begin
      fs_per <= sclk_cnt;
      sclk_cnt <= int'(sclk_en);
    end else begin
      sclk_cnt <= sclk_cnt + int'(sclk_en);
    end
  end

  task automatic final_report();
    if (n_errors == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string what);
    logic [7:0] d;
    dsp.rd(a, d);
    if (dsp.timed_out) begin
      n_errors++;
      final_report();
    end
    check({8'h00, d}, {8'h00, exp}, what);
  endtask
  task automatic settle();
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  function automatic logic [4:0] step(input logic [2:0] c);
    return c[2] ? 5'h0C : {2'b00, c} * 5'h03;
  endfunction
  function automatic chain_out_s chain_exp(input logic [7:0] d);
    chain_out_s e;
    e = '{3'h0, 1'b1, 1'b0, 1'b0, 1'b0};
    if (d[0]) begin
      e.slave_count = d[7:5];
      e.rx_word_16 = !d[4];
      e.rx_lsb_forced = d[4];
      e.rx_lsb_value = d[4] && !d[3];
      e.sync_spacing_16 = d[2];
    end
    return e;
  endfunction

  initial begin
    logic [7:0] f, c, d;
    logic [11:0] g;
    int i, n;
    resetn = 1'b0;
    sclk_en = 1'b0;
    intl = 1'b1;
    rev = 4'hA;
    ring = 1'b0;
    req_drv = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    resetn = 1'b1;
    repeat (6) @(posedge clk_sys);
    #1;
    check({4'h0, gain_out}, 16'h0000, "gain_out reset");
    check({13'h0, auto_cal, pin_oe_n, filt}, 16'h0006, "reset levels");
    rdc(8'h0D, {1'b0, intl, rev, 2'b00}, "gain id reset");
    rdc(8'h0E, 8'h02, "chain reset");
    rdc(8'h0F, 8'h00, "fine reset");
    rdc(8'h10, 8'h08, "filter reset");
    rdc(8'h11, 8'h00, "cal reset");
    for (i = 0; i < 16; i++) begin
      f = 8'($random(seed));
      c = 8'($random(seed));
      if (f[6:4] != 3'h0) c[0] = 1'b0;
      if (f[2:0] != 3'h0) c[1] = 1'b0;
      intl = 1'($random(seed));
      rev = 4'($random(seed));
      dsp.wr(8'h0F, f);
      dsp.wr(8'h0D, c);
      settle();
      g = {f[7], f[3], step(f[6:4]) + (c[0] ? 5'h03 : 5'h00),
        step(f[2:0]) + (c[1] ? 5'h06 : 5'h00)};
      check({4'h0, gain_out}, {4'h0, g}, "gain_out");
      rdc(8'h0F, f, "fine readback");
      rdc(8'h0D, {1'b0, intl, rev, c[1:0]}, "gain readback");
    end
    // Coarse-only, then fine-only with transmit mute; random draws rarely hit either
    for (i = 0; i < 2; i++) begin
      dsp.wr(8'h0D, i[0] ? 8'h00 : 8'h03);
      dsp.wr(8'h0F, i[0] ? 8'hC5 : 8'h00);
      settle();
      check({4'h0, gain_out}, i[0] ? {6'h02, 5'h0C, 5'h0C} : {6'h00, 5'h03, 5'h06},
        "gain corner");
    end
    // Every word select code with chain off, then on, then off again
    for (i = 0; i < 12; i++) begin
      d = 8'($random(seed));
      d[4:3] = i[1:0];
      d[0] = i[2];
      if (d[0] && d[7:5] != 3'h0) d[2] = 1'b1;
      ring = 1'($random(seed));
      req_drv = 1'($random(seed));
      dsp.wr(8'h0E, d);
      repeat (6) @(posedge clk_sys);
      #1;
      check({9'h0, chain_out}, {9'h0, chain_exp(d)}, "chain_out");
      if (d[0]) check({13'h0, pin_oe_n, pin_out, sec_req}, {13'h0, 1'b0, ring ~^ d[1], 1'b0},
        "chain pins");
      else check({12'h0, pin_oe_n, pin_out, ring_sync_out, sec_req},
        {12'h0, 1'b1, 1'b1, !ring, req_drv}, "plain pins");
      rdc(8'h0E, d, "chain readback");
    end
    for (i = 0; i < 3; i++) begin
      d = (i == 0) ? 8'h01 : (i == 1) ? 8'h05 : 8'h04;
      dsp.wr(8'h0E, d);
      fs_per = 0;
      repeat (200) @(posedge clk_sys);
      #1;
      check(16'(fs_per), (i == 1) ? 16'h0010 : 16'h0020, "sync spacing");
    end
    for (i = 0; i < 2; i++) begin
      d = i[0] ? 8'h08 : 8'h18;
      dsp.wr(8'h10, d);
      settle();
      check({15'h0, filt}, {15'h0, !i[0]}, "filter select");
      rdc(8'h10, d, "filter readback");
    end
    for (i = 0; i < 3; i++) begin
      d = (i == 0) ? 8'h40 : (i == 1) ? 8'h20 : 8'h7F;
      dsp.wr(8'h11, d);
      n = 0;
      repeat (3) begin
        n = n + ((cal_start === 1'b1) ? 1 : 0);
        @(posedge clk_sys);
        #1;
      end
      check(16'(n), {15'h0, d[6]}, "cal pulses");
      check({15'h0, auto_cal}, {15'h0, !d[5]}, "auto cal");
      rdc(8'h11, d & 8'h60, "cal readback");
    end
    dsp.wr(8'h12, 8'hFF);
    rdc(8'h12, 8'h00, "unmapped");
    final_report();
  end
endmodule // test_daa_gain_chain_filter_cal_regs
